// ### core/acs_ctrl_top.sv
// converter start-up sequencing and control register file on AXI4-Lite
// Operation
// - readable output with default gain and threshold
// - settled flag marks valid data after settling
// - gain and threshold writable and readable after start-up
// - write is address and 16-bit data, taken in either order
// - control register at address one, resets zero
// - control drives reference buffer, amplifier, power-down
// - bit 14 makes next read return threshold
// - bit 13 makes next read return gain
// - bits 14 to 11 and 9 self-clear
`timescale 1ns/1ps
module acs_ctrl_top #(
  parameter int SETTLE_N = acs_pkg::SETTLE_SAMPLES,
  parameter logic ID_BIT = 1'b0 // arbitrary identity value
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // axi4-lite write channels
  input wire logic [acs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [acs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic align_n_pin,
  input wire logic [1:0] dec_rate_pin,
  // conversion datapath, same clock
  input wire logic [23:0] conv_data,
  input wire logic conv_valid,
  input wire logic ovr_in,
  // analog and filter controls
  output logic ref_buf_off,
  output logic amp_off,
  output logic power_down,
  output logic bypass_ref,
  output logic low_power,
  output logic [15:0] gain_value,
  output logic [15:0] ovr_threshold,
  output logic sync_start,
  output logic filter_settled_flag,
  // interrupt
  output logic irq
);
  localparam int SCW = $clog2(SETTLE_N + 1);
  localparam logic [SCW-1:0] SETTLE_LAST = SCW'(SETTLE_N - 1);
  localparam logic [1:0] START_LAST = 2'(acs_pkg::STARTUP_CYCLES - 1);

  // ------------------------------------------------------------
  // pins and start-up
  // ------------------------------------------------------------
  logic align_n_s;
  logic [1:0] dec_rate_s;
  logic align_done;
  logic [1:0] start_cnt_reg;
  logic startup_done_reg;

  // idle level high so an unused alignment input never fires
  acs_sync2 #(.WIDTH(1), .RESET_VAL(1'b1)) u_align_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(align_n_pin),
    .q(align_n_s)
  );

  acs_sync2 #(.WIDTH(2), .RESET_VAL(2'b00)) u_dec_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(dec_rate_pin),
    .q(dec_rate_s)
  );

  // pulses shorter than the least width are dropped
  acs_low_detect #(.MIN_LOW(acs_pkg::ALIGN_LOW_MIN)) u_align_det (
    .mclk(mclk),
    .rst_n(rst_n),
    .level_n(align_n_s),
    .done(align_done)
  );

  // bus stays closed until the post-reset wait has passed
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      start_cnt_reg <= 2'h0;
      startup_done_reg <= 1'b0;
    end
    else if (!startup_done_reg)
    begin
      start_cnt_reg <= start_cnt_reg + 2'h1;
      startup_done_reg <= (start_cnt_reg == START_LAST);
    end
  end

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic aw_have_reg, w_have_reg;
  logic [3:0] awidx_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [15:0] ctrl_reg, gain_reg, ovr_reg;
  logic [23:0] conv_reg;
  localparam int INT_W_L = acs_pkg::INT_W;
  logic [INT_W_L-1:0] int_stat_reg, int_en_reg;
  logic settled_reg, ovr_flag_reg;
  logic [SCW-1:0] settle_cnt_reg;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire have_a = aw_have_reg | aw_take;
  wire have_w = w_have_reg | w_take;
  wire do_write = have_a & have_w;
  wire [3:0] widx = aw_take ? s_axi_awaddr[5:2] : awidx_reg;
  wire [31:0] wd = w_take ? s_axi_wdata : wdata_reg;
  wire [3:0] ws = w_take ? s_axi_wstrb : wstrb_reg;
  wire wr_ctrl = do_write & (widx == acs_pkg::IDX_CTRL);
  wire wr_gain = do_write & (widx == acs_pkg::IDX_GAIN);
  wire wr_ovr = do_write & (widx == acs_pkg::IDX_OVR);
  wire wr_clr = do_write & (widx == acs_pkg::IDX_INT_CLR);
  wire wr_en = do_write & (widx == acs_pkg::IDX_INT_EN);
  wire wr_known = (widx == acs_pkg::IDX_CTRL) | (widx == acs_pkg::IDX_GAIN) |
                  (widx == acs_pkg::IDX_OVR) | (widx == acs_pkg::IDX_STAT) |
                  (widx == acs_pkg::IDX_RDBK) | (widx == acs_pkg::IDX_INT_STAT) |
                  (widx == acs_pkg::IDX_INT_CLR) | (widx == acs_pkg::IDX_INT_EN);
  // byte-lane merge for the 16-bit registers
  wire [15:0] wmask = {{8{ws[1]}}, {8{ws[0]}}};
  wire [15:0] ctrl_wval = ((ctrl_reg & ~wmask) | (wd[15:0] & wmask)) & acs_pkg::CTRL_WMASK;
  wire [15:0] gain_wval = (gain_reg & ~wmask) | (wd[15:0] & wmask);
  wire [15:0] ovr_wval = (ovr_reg & ~wmask) | (wd[15:0] & wmask);

  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [3:0] ridx = s_axi_araddr[5:2];
  wire rd_rdbk = ar_take & (ridx == acs_pkg::IDX_RDBK);

  // ------------------------------------------------------------
  // status and readback words
  // ------------------------------------------------------------
  wire [15:0] stat_word = {ID_BIT, 4'h0, settled_reg, ctrl_reg[acs_pkg::CTRL_LPWR], ovr_flag_reg,
                           3'h0, ctrl_reg[acs_pkg::CTRL_REF_OFF], ctrl_reg[acs_pkg::CTRL_AMP_OFF],
                           1'b0, dec_rate_s};
  // one select honoured at a time; threshold wins, then gain, then status
  wire sel_ovr = ctrl_reg[acs_pkg::CTRL_READ_THRESHOLD_SELECT];
  wire sel_gain = ctrl_reg[acs_pkg::CTRL_RD_GAIN] & ~sel_ovr;
  wire sel_stat = ctrl_reg[acs_pkg::CTRL_RD_STAT] & ~sel_ovr & ~sel_gain;
  wire [31:0] rdbk_word = sel_ovr ? {16'h0000, ovr_reg} :
                          sel_gain ? {16'h0000, gain_reg} :
                          sel_stat ? {16'h0000, stat_word} :
                          {7'h00, settled_reg, conv_reg};
  wire [31:0] rd_word = (ridx == acs_pkg::IDX_CTRL) ? {16'h0000, ctrl_reg} :
                        (ridx == acs_pkg::IDX_GAIN) ? {16'h0000, gain_reg} :
                        (ridx == acs_pkg::IDX_OVR) ? {16'h0000, ovr_reg} :
                        (ridx == acs_pkg::IDX_STAT) ? {16'h0000, stat_word} :
                        (ridx == acs_pkg::IDX_RDBK) ? rdbk_word :
                        (ridx == acs_pkg::IDX_INT_STAT) ? {29'h0, int_stat_reg} :
                        (ridx == acs_pkg::IDX_INT_EN) ? {29'h0, int_en_reg} : 32'h0000_0000;
  wire rd_known = (ridx == acs_pkg::IDX_CTRL) | (ridx == acs_pkg::IDX_GAIN) |
                  (ridx == acs_pkg::IDX_OVR) | (ridx == acs_pkg::IDX_STAT) |
                  (ridx == acs_pkg::IDX_RDBK) | (ridx == acs_pkg::IDX_INT_STAT) |
                  (ridx == acs_pkg::IDX_INT_CLR) | (ridx == acs_pkg::IDX_INT_EN);

  // ------------------------------------------------------------
  // handshake next values
  // ------------------------------------------------------------
  wire aw_have_next = have_a & ~do_write;
  wire w_have_next = have_w & ~do_write;
  wire bvalid_next = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire awready_next = startup_done_reg & ~aw_have_next & ~bvalid_next;
  wire wready_next = startup_done_reg & ~w_have_next & ~bvalid_next;
  wire arready_next = startup_done_reg & ~rvalid_next;

  // write and read channel flops
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awidx_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= acs_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= acs_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      if (aw_take)
        awidx_reg <= s_axi_awaddr[5:2];
      if (w_take)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      s_axi_awready <= awready_next;
      s_axi_wready <= wready_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_arready <= arready_next;
      s_axi_rvalid <= rvalid_next;
      if (do_write)
        s_axi_bresp <= wr_known ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
      if (ar_take)
      begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
      end
    end
  end

  // ------------------------------------------------------------
  // control, gain and threshold registers
  // ------------------------------------------------------------
  // selects drop once the readback is read, sync drops after one cycle; a write wins
  wire [15:0] ctrl_kept = ctrl_reg & ~(rd_rdbk ? acs_pkg::CTRL_SEL_MASK : 16'h0000) &
                          ~(16'h0001 << acs_pkg::CTRL_SYNC);
  wire [15:0] ctrl_next = wr_ctrl ? ctrl_wval : ctrl_kept;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= acs_pkg::CTRL_RESET;
      gain_reg <= acs_pkg::GAIN_RESET;
      ovr_reg <= acs_pkg::OVR_RESET;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      if (wr_gain)
        gain_reg <= gain_wval;
      if (wr_ovr)
        ovr_reg <= ovr_wval;
    end
  end

  // control fields straight from the register bits
  assign ref_buf_off = ctrl_reg[acs_pkg::CTRL_REF_OFF];
  assign amp_off = ctrl_reg[acs_pkg::CTRL_AMP_OFF];
  assign power_down = ctrl_reg[acs_pkg::CTRL_PWR_DOWN];
  assign bypass_ref = ctrl_reg[acs_pkg::CTRL_BYPASS];
  assign low_power = ctrl_reg[acs_pkg::CTRL_LPWR];
  assign gain_value = gain_reg;
  assign ovr_threshold = ovr_reg;
  assign filter_settled_flag = settled_reg;

  // ------------------------------------------------------------
  // filter settling
  // ------------------------------------------------------------
  // soft sync bit and qualified pin pulse both restart the filter
  wire restart = ctrl_reg[acs_pkg::CTRL_SYNC] | align_done;
  wire settle_hit = conv_valid & ~settled_reg & (settle_cnt_reg == SETTLE_LAST);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      settle_cnt_reg <= '0;
      settled_reg <= 1'b0;
      conv_reg <= 24'h000000;
      ovr_flag_reg <= 1'b0;
      sync_start <= 1'b0;
    end
    else
    begin
      sync_start <= restart;
      ovr_flag_reg <= ovr_in;
      if (conv_valid)
        conv_reg <= conv_data;
      // power-down invalidates the filter history as a restart does
      if (restart | power_down)
      begin
        settle_cnt_reg <= '0;
        settled_reg <= 1'b0;
      end
      else if (conv_valid & ~settled_reg)
      begin
        settle_cnt_reg <= settle_cnt_reg + SCW'(1);
        settled_reg <= settle_hit;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  wire [INT_W_L-1:0] int_ev = {ovr_in & ~ovr_flag_reg, restart, settle_hit};
  // a new event outranks a clear in the same cycle
  wire [INT_W_L-1:0] int_stat_next = (int_stat_reg & ~(wr_clr ? wd[INT_W_L-1:0] : 3'h0)) | int_ev;
  wire [INT_W_L-1:0] int_en_next = wr_en ? wd[INT_W_L-1:0] : int_en_reg;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      int_stat_reg <= 3'h0;
      int_en_reg <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      int_stat_reg <= int_stat_next;
      int_en_reg <= int_en_next;
      irq <= |(int_stat_next & int_en_next);
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence write_done_s;
    do_write ##1 s_axi_bvalid;
  endsequence

  write_resp_a: assert property (@(posedge mclk) disable iff (!rst_n)
    do_write |-> write_done_s) else $error("write not answered next cycle");
  ctrl_reset_a: assert property (@(posedge mclk)
    $past(!rst_n) && rst_n |-> ctrl_reg == 16'h0000) else $error("control not zero after reset");
  defaults_a: assert property (@(posedge mclk) $past(!rst_n) && rst_n |->
    gain_reg == 16'hA000 && ovr_reg == 16'hCCCC) else $error("gain or threshold default wrong");
  sync_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl_reg[9] && !wr_ctrl |=> !ctrl_reg[9]) else $error("sync bit did not clear");
  sel_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_rdbk && !wr_ctrl |=> ctrl_reg[14:11] == 4'h0) else $error("read select did not clear");
  read_threshold_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_rdbk && ctrl_reg[14] |=> s_axi_rdata == {16'h0000, $past(ovr_reg)}) else $error("threshold not returned");
  rd_gain_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_rdbk && ctrl_reg[13] && !ctrl_reg[14] |=> s_axi_rdata == {16'h0000, $past(gain_reg)})
    else $error("gain not returned");
  settle_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    restart |=> !settled_reg [*2]) else $error("settled flag after restart");
  settle_rise_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(settled_reg) |-> $past(conv_valid) && $past(settle_cnt_reg) == SETTLE_LAST)
    else $error("settled flag raised early");
  pwr_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_ctrl |=> power_down == $past(ctrl_wval[3]) && amp_off == $past(ctrl_wval[0]))
    else $error("control outputs not following write");
  gate_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !startup_done_reg |-> !s_axi_awready && !s_axi_arready) else $error("bus open during start-up");
endmodule

// ### core/acs_low_detect.sv
// qualifies a low pulse of least length and flags its release
`timescale 1ns/1ps
module acs_low_detect #(
  parameter int MIN_LOW = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // synchronised level, low active
  input wire logic level_n,
  // one-cycle pulse at release of a long enough low
  output logic done
);
  localparam int CW = $clog2(MIN_LOW + 1);
  localparam logic [CW-1:0] CMAX = CW'(MIN_LOW);
  logic [CW-1:0] cnt_reg;
  wire long_enough = (cnt_reg == CMAX);

  // saturating count of low cycles; short glitches never qualify
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      done <= 1'b0;
    end
    else
    begin
      done <= level_n & long_enough;
      if (level_n)
        cnt_reg <= '0;
      else if (!long_enough)
        cnt_reg <= cnt_reg + CW'(1);
    end
  end
endmodule

// ### core/acs_pkg.sv
// shared constants for the converter start-up and control register block
package acs_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CTRL = 4'h1;
  localparam logic [3:0] IDX_GAIN = 4'h4;
  localparam logic [3:0] IDX_OVR = 4'h5;
  localparam logic [3:0] IDX_STAT = 4'h6;
  localparam logic [3:0] IDX_RDBK = 4'h7;
  localparam logic [3:0] IDX_INT_STAT = 4'h8;
  localparam logic [3:0] IDX_INT_CLR = 4'h9;
  localparam logic [3:0] IDX_INT_EN = 4'hA;
  localparam int ADDR_W = 6;
  // control register fields
  localparam int CTRL_READ_THRESHOLD_SELECT = 14;
  localparam int CTRL_RD_GAIN = 13;
  localparam int CTRL_RD_STAT = 11;
  localparam int CTRL_SYNC = 9;
  localparam int CTRL_BYPASS = 7;
  localparam int CTRL_PWR_DOWN = 3;
  localparam int CTRL_LPWR = 2;
  localparam int CTRL_REF_OFF = 1;
  localparam int CTRL_AMP_OFF = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h6A8F;
  localparam logic [15:0] CTRL_SEL_MASK = 16'h7800;
  localparam logic [15:0] GAIN_RESET = 16'hA000;
  localparam logic [15:0] OVR_RESET = 16'hCCCC;
  // status word fields
  localparam int STAT_ID = 15;
  localparam int STAT_SETTLED = 10;
  localparam int STAT_LPWR = 9;
  localparam int STAT_OVR = 8;
  localparam int STAT_REF_OFF = 4;
  localparam int STAT_AMP_OFF = 3;
  // interrupt bits
  localparam int INT_W = 3;
  localparam int INT_SETTLED = 0;
  localparam int INT_SYNC = 1;
  localparam int INT_OVR = 2;
  // start-up timing in master clock cycles; settling length in conversion samples
  localparam int STARTUP_CYCLES = 2;
  localparam int ALIGN_LOW_MIN = 4;
  localparam int SETTLE_SAMPLES = 64;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### core/acs_sync2.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module acs_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // level in and out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      meta_reg <= RESET_VAL;
      q <= RESET_VAL;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ### tb/acs_host_model.sv
// host-side model: alignment pin and conversion sample source
`timescale 1ns/1ps
module acs_host_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // commands from the bench
  input wire logic align_go,
  input wire logic [3:0] align_len,
  input wire logic conv_on,
  // toward the converter
  output logic align_n_pin,
  output logic [23:0] conv_data,
  output logic conv_valid
);
  logic [3:0] low_cnt;
  logic [1:0] div_cnt;
  // ----------------------------------------
  // alignment pulse
  // ----------------------------------------
  // pulse only after reset, held low for align_len cycles
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      low_cnt <= 4'h0;
    end
    else if (align_go)
    begin
      low_cnt <= align_len;
    end
    else if (low_cnt != 4'h0)
    begin
      low_cnt <= low_cnt - 4'h1;
    end
  end
  // idle level is high whenever no alignment is under way
  assign align_n_pin = (low_cnt == 4'h0);
  // ----------------------------------------
  // sample stream
  // ----------------------------------------
  // one word every fourth cycle; data keeps moving so a stale word never looks current
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      div_cnt <= 2'h0;
      conv_data <= 24'h000000;
      conv_valid <= 1'b0;
    end
    else
    begin
      div_cnt <= div_cnt + 2'h1;
      conv_data <= {conv_data[22:0], ~conv_data[23]};
      conv_valid <= conv_on && (div_cnt == 2'h3);
    end
  end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the converter control register block
`timescale 1ns/1ps
module tb_top;
  localparam int SETTLE_N = 4;
  localparam int LIMIT = 6000;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [acs_pkg::ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic align_go = 1'b0, conv_on = 1'b0;
  logic [3:0] align_len = 4'h4;
  logic awready, wready, bvalid, arready, rvalid, align_n, conv_valid, settled, irq;
  logic ref_off, amp_off, pdown, bypass, lpwr, sync_st;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [23:0] conv_data;
  logic [15:0] gain, ovr;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_sync = 0;
  int cyc = 0;
  always #10 mclk = ~mclk;
  acs_ctrl_top #(.SETTLE_N(SETTLE_N)) acs_ctrl_top_inst (
    .mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .align_n_pin(align_n), .dec_rate_pin(2'b10), .conv_data(conv_data), .conv_valid(conv_valid),
    .ovr_in(1'b0), .ref_buf_off(ref_off), .amp_off(amp_off), .power_down(pdown),
    .bypass_ref(bypass), .low_power(lpwr), .gain_value(gain), .ovr_threshold(ovr),
    .sync_start(sync_st), .filter_settled_flag(settled), .irq(irq)
  );
  acs_host_model acs_host_model_inst (
    .mclk(mclk), .rst_n(rst_n), .align_go(align_go), .align_len(align_len), .conv_on(conv_on),
    .align_n_pin(align_n), .conv_data(conv_data), .conv_valid(conv_valid)
  );
  // ----------------------------------------
  // verdict and hang guard
  // ----------------------------------------
  task automatic print_verdict();
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // a stuck handshake would otherwise hang the run forever
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    // filter restart pulses, counted for the sync checks
    if (sync_st)
      n_sync <= n_sync + 1;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  // ----------------------------------------
  // bus master
  // ----------------------------------------
  // address and data offered together, each released once taken
  task automatic wr(input logic [3:0] idx, input logic [15:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge mclk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge mclk);
      if (awready && !aw_ok)
      begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wready && !w_ok)
      begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(posedge mclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  // masked read: only the bits set in m are judged
  task automatic rdmask(input string nm, input logic [3:0] idx, input logic [31:0] e, input logic [1:0] er,
                        input logic [31:0] m);
    @(posedge mclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    chk(nm, e, rd & m);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  task automatic rdchk(input string nm, input logic [3:0] idx, input logic [31:0] e, input logic [1:0] er);
    rdmask(nm, idx, e, er, 32'hFFFFFFFF);
  endtask
  task automatic align(input logic [3:0] n);
    @(posedge mclk);
    align_len <= n;
    align_go <= 1'b1;
    @(posedge mclk);
    align_go <= 1'b0;
    repeat (12) @(posedge mclk); // pulse plus two sync flops and detect
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdchk("ctrl", acs_pkg::IDX_CTRL, 32'h00000000, acs_pkg::RESP_OKAY);
    rdchk("gain", acs_pkg::IDX_GAIN, 32'h0000A000, acs_pkg::RESP_OKAY);
    rdchk("ovr", acs_pkg::IDX_OVR, 32'h0000CCCC, acs_pkg::RESP_OKAY);
    chk("settled", 32'h0, {31'h0, settled});
  endtask
  task automatic t_regs();
    wr(acs_pkg::IDX_GAIN, 16'h1234, acs_pkg::RESP_OKAY);
    wr(acs_pkg::IDX_OVR, 16'h8001, acs_pkg::RESP_OKAY);
    rdchk("gain", acs_pkg::IDX_GAIN, 32'h00001234, acs_pkg::RESP_OKAY);
    rdchk("ovr", acs_pkg::IDX_OVR, 32'h00008001, acs_pkg::RESP_OKAY);
    chk("gain_port", 32'h1234, {16'h0, gain});
    chk("ovr_port", 32'h8001, {16'h0, ovr});
    wr(4'hF, 16'hFFFF, acs_pkg::RESP_SLVERR);
    rdchk("unmapped", 4'hF, 32'h00000000, acs_pkg::RESP_SLVERR);
  endtask
  task automatic t_ctrl();
    wr(acs_pkg::IDX_CTRL, 16'h008F, acs_pkg::RESP_OKAY);
    chk("ctrl_pins", 32'h1F, {27'h0, bypass, pdown, lpwr, ref_off, amp_off});
    wr(acs_pkg::IDX_CTRL, 16'h0807, acs_pkg::RESP_OKAY);
    rdchk("status", acs_pkg::IDX_RDBK, 32'h0000021A, acs_pkg::RESP_OKAY);
    rdchk("ctrl", acs_pkg::IDX_CTRL, 32'h00000007, acs_pkg::RESP_OKAY);
  endtask
  task automatic t_sel();
    wr(acs_pkg::IDX_CTRL, 16'h4000, acs_pkg::RESP_OKAY);
    rdchk("read_threshold", acs_pkg::IDX_RDBK, 32'h00008001, acs_pkg::RESP_OKAY);
    rdchk("ctrl", acs_pkg::IDX_CTRL, 32'h00000000, acs_pkg::RESP_OKAY);
    wr(acs_pkg::IDX_CTRL, 16'h2000, acs_pkg::RESP_OKAY);
    rdchk("rd_gain", acs_pkg::IDX_RDBK, 32'h00001234, acs_pkg::RESP_OKAY);
  endtask
  task automatic t_settle();
    int w;
    wr(acs_pkg::IDX_INT_EN, 16'h0003, acs_pkg::RESP_OKAY);
    align(4'h3);
    rdchk("short_pulse", acs_pkg::IDX_INT_STAT, 32'h0, acs_pkg::RESP_OKAY);
    align(4'h4);
    rdchk("restart", acs_pkg::IDX_INT_STAT, 32'h2, acs_pkg::RESP_OKAY);
    chk("sync_pin", 32'h1, n_sync);
    chk("irq", 32'h1, {31'h0, irq});
    wr(acs_pkg::IDX_INT_CLR, 16'h0002, acs_pkg::RESP_OKAY);
    chk("irq_clr", 32'h0, {31'h0, irq});
    conv_on <= 1'b1;
    w = 0;
    while (settled !== 1'b1 && w < 100)
    begin
      @(posedge mclk);
      w++;
    end
    chk("settled", 32'h1, {31'h0, settled});
    conv_on <= 1'b0;
    rdchk("int_settled", acs_pkg::IDX_INT_STAT, 32'h1, acs_pkg::RESP_OKAY);
    rdmask("rdbk_flag", acs_pkg::IDX_RDBK, 32'h01000000, acs_pkg::RESP_OKAY, 32'hFF000000);
    wr(acs_pkg::IDX_CTRL, 16'h0200, acs_pkg::RESP_OKAY);
    // the flag drops one edge after the sync bit lands
    @(posedge mclk);
    chk("resettle", 32'h0, {31'h0, settled});
    rdchk("ctrl", acs_pkg::IDX_CTRL, 32'h00000000, acs_pkg::RESP_OKAY);
    chk("sync_soft", 32'h2, n_sync);
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_ctrl();
    t_sel();
    t_settle();
    print_verdict();
  end
endmodule
